//--- sbdt_defines.svh
// How it works
// - Fourth chip select decodes block three in 32k mode
// - Peripheral select zero for data 0000h-3FFFh
// - Peripheral select one for data 4000h-7FFFh
// - Peripheral select two, 8000h-BFFFh, never backup-gated
// - Peripheral select three, C000h-FFFFh, never backup-gated
// - Backup forces chip selects and peripheral zero/one high
// - Loader entered on debounced falling loader edge
// - Loader input low at power-up starts loader
// - Drive reset pin low while supply under minimum
// - Reset pin pulled low externally resets device
// - Backup indicator low while on battery
// - Size pin high: 32k parts; low: 128k part
// - Tamper input erases secrets, cuts switched supply
// - Tamper erase acts always, like lock clear
// - Key is 64 bits, never readable
// - Key loaded only from random generator
// - Unbacked copy of chip select zero
// - 128k mode: selects one/two carry A16/A15
// - Write strobe for program blocks only in loader mode
`ifndef SBDT_DEFINES_SVH
`define SBDT_DEFINES_SVH

// Register byte offsets
`define SBDT_OFF_CTRL      32'h0000_0000
`define SBDT_OFF_STAT      32'h0000_0004
`define SBDT_OFF_VR_IDX    32'h0000_0008
`define SBDT_OFF_VR_DATA   32'h0000_000c
`define SBDT_OFF_PART      32'h0000_0010

// Control bits
`define SBDT_CTRL_PES      0
`define SBDT_CTRL_LOCK     1
`define SBDT_CTRL_KEYLD    2
`define SBDT_CTRL_LDEXIT   3

// Status bits
`define SBDT_ST_LOADER     0
`define SBDT_ST_BACKUP     1
`define SBDT_ST_PFAIL      2
`define SBDT_ST_MEM_SIZE_SEL       3
`define SBDT_ST_TAMPER     4
`define SBDT_ST_KEYVAL     5
`define SBDT_ST_LOCK       6

// Sizes
`define SBDT_KEY_W         64
`define SBDT_VR_DEPTH      48
`define SBDT_VR_IDX_W      6
`define SBDT_NSYNC         6

// Pin synchroniser resting values: loader, reset pin, size pin idle high
`define SBDT_SYNC_RST      6'h13
// Cycles before the loader strap is sampled after reset release
`define SBDT_BOOT_CYC      2'h3

// Bus responses
`define SBDT_RESP_OK       2'h0
`define SBDT_RESP_ERR      2'h2

`endif

//--- sbdt_key_if.sv
`include "sbdt_defines.svh"
interface sbdt_key_if;
    logic                      erase;     // Wipe key and vector RAM
    logic                      key_load;  // Take key from generator
    logic [`SBDT_KEY_W-1:0]    trng;      // Random generator word
    logic [`SBDT_KEY_W-1:0]    key;       // Key to encryptors only
    logic                      key_valid; // Key present
    logic                      vr_we;     // Vector RAM write
    logic [`SBDT_VR_IDX_W-1:0] vr_idx;    // Vector RAM index
    logic [7:0]                vr_wdata;  // Vector RAM write byte
    logic [7:0]                vr_rdata;  // Vector RAM read byte
    modport ctl (output erase, key_load, trng, vr_we, vr_idx, vr_wdata,
                 input key, key_valid, vr_rdata);
    modport store (input erase, key_load, trng, vr_we, vr_idx, vr_wdata,
                   output key, key_valid, vr_rdata);
endinterface

//--- sbdt_keystore.sv
`include "sbdt_defines.svh"
module sbdt_keystore
    import sbdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    sbdt_key_if.store kif
);
    logic [`SBDT_KEY_W-1:0] key_q;                      // Secret key
    logic                   valid_q;                    // Key loaded
    sbdt_byte_t             vram_q [`SBDT_VR_DEPTH];    // Vector RAM
    logic                   idx_ok;                     // Index in range

    assign idx_ok = (kif.vr_idx < 6'(`SBDT_VR_DEPTH));

    // Key: erase beats load; only the generator feeds it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            key_q   <= '0;
            valid_q <= 1'b0;
        end
        else if (kif.erase)
        begin
            key_q   <= '0;
            valid_q <= 1'b0;
        end
        else if (kif.key_load)
        begin
            key_q   <= kif.trng;
            valid_q <= 1'b1;
        end
    end

    // Vector RAM: whole array wiped in one cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < `SBDT_VR_DEPTH; i++)
                vram_q[i] <= 8'h00;
        end
        else if (kif.erase)
        begin
            for (int i = 0; i < `SBDT_VR_DEPTH; i++)
                vram_q[i] <= 8'h00;
        end
        else if (kif.vr_we && idx_ok)
        begin
            vram_q[kif.vr_idx] <= kif.vr_wdata;
        end
    end

    assign kif.key       = key_q;
    assign kif.key_valid = valid_q;
    assign kif.vr_rdata  = idx_ok ? vram_q[kif.vr_idx] : 8'h00;

    erase_key_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        kif.erase |=> (kif.key == '0) && !kif.key_valid)
        else $error("key not wiped after erase");
    vram_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (kif.vr_we && idx_ok && !kif.erase) ##1 (kif.vr_idx == $past(kif.vr_idx))
        |-> kif.vr_rdata == $past(kif.vr_wdata))
        else $error("vector RAM write lost");
endmodule // sbdt_keystore

//--- sbdt_pin_model.sv
module sbdt_pin_model
(
    input  wire logic oe_i,   // Device pulls the reset pin low
    input  wire logic pull_i, // Another part pulls it low
    output logic      pin_o   // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open drain with pull-up: any driver wins over the pull-up
    assign pin_o = !(oe_i || pull_i);
endmodule // sbdt_pin_model

//--- sbdt_pkg.sv
package sbdt_pkg;
    // Execution mode, one-hot
    typedef enum logic [2:0] {
        SBDT_BOOT = 3'h1,
        SBDT_NORM = 3'h2,
        SBDT_LOAD = 3'h4
    } sbdt_mode_t;
    typedef logic [7:0] sbdt_byte_t;
endpackage

//--- sbdt_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`include "sbdt_defines.svh"
module sbdt_top
    import sbdt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [31:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // Core memory request
    input  wire logic        mem_req_i,
    input  wire logic [16:0] mem_addr_i,
    input  wire logic        mem_data_space_i,
    input  wire logic        mem_write_i,
    input  wire logic [63:0] trng_i,
    output logic [63:0]      enc_key_o,
    output logic             core_reset_o,
    output logic             loader_mode_o,
    // Pins
    input  wire logic        loader_entry_n_i,
    input  wire logic        power_fail_reset_io_n_i,
    output logic             power_fail_reset_io_n_o,
    output logic             power_fail_reset_io_n_oe_o,
    input  wire logic        vcc_below_min_i,
    input  wire logic        vcc_below_batt_i,
    output logic             backup_active_n_o,
    input  wire logic        mem_size_sel_i,
    input  wire logic        tamper_destroy_in_i,
    output logic             switched_supply_out_o,
    output logic             chip_sel_block0_n_o,
    output logic             chip_sel_block1_n_o,
    output logic             chip_sel_block2_n_o,
    output logic             chip_sel_block3_n_o,
    output logic             chip_sel_block0_unbacked_n_o,
    output logic             periph_sel0_n_o,
    output logic             periph_sel1_n_o,
    output logic             periph_sel2_n_o,
    output logic             periph_sel3_n_o,
    output logic             write_strobe_n_o
);
    // ---------------- Pin synchronisers
    logic [`SBDT_NSYNC-1:0] pin_raw;   // Asynchronous pin levels
    logic [`SBDT_NSYNC-1:0] s1_q;      // First stage, read by s2 only
    logic [`SBDT_NSYNC-1:0] s2_q;      // Second stage
    logic [`SBDT_NSYNC-1:0] s3_q;      // Third stage
    logic [`SBDT_NSYNC-1:0] pin_q;     // Accepted level

    assign pin_raw = {tamper_destroy_in_i, mem_size_sel_i, vcc_below_batt_i,
                      vcc_below_min_i, power_fail_reset_io_n_i, loader_entry_n_i};

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_q  <= `SBDT_SYNC_RST;
            s2_q  <= `SBDT_SYNC_RST;
            s3_q  <= `SBDT_SYNC_RST;
            pin_q <= `SBDT_SYNC_RST;
        end
        else
        begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end

    logic loader_n_s;   // Loader entry, low active
    logic pin_rst_n_s;  // Shared reset pin level
    logic vcc_low_s;    // Supply below minimum
    logic backup_s;     // Running from battery
    logic size32k_s;    // 32k parts selected
    logic tamper_s;     // Tamper input active
    assign {tamper_s, size32k_s, backup_s, vcc_low_s, pin_rst_n_s, loader_n_s} = pin_q;

    // ---------------- Power-fail, backup, tamper pins
    // Open drain: output is always low, enable decides
    assign power_fail_reset_io_n_o    = 1'b0;
    assign power_fail_reset_io_n_oe_o = vcc_low_s;
    assign core_reset_o               = vcc_low_s | !pin_rst_n_s;
    assign backup_active_n_o          = !backup_s;

    // Supply switch cut while tamper is active
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            switched_supply_out_o <= 1'b1;
        else
            switched_supply_out_o <= !tamper_s;
    end

    // ---------------- Registers
    logic       pes_q;       // Peripheral space select
    logic       lock_q;      // Security lock
    logic       tamper_st_q; // Sticky tamper seen
    logic [5:0] vr_idx_q;    // Vector RAM pointer
    logic [3:0] loader_entry_n_mask_q; // Blocks held as program
    logic       lock_clr;    // Lock cleared by software
    logic       key_ld;      // Key load request
    logic       ld_exit;     // Leave loader request
    sbdt_mode_t mode_q;      // Execution mode
    logic [1:0] boot_cnt_q;  // Strap settle counter
    logic       loader_prev_q; // Previous loader level

    sbdt_key_if kif ();

    // AXI write side: address and data held in either order
    logic        aw_full_q;
    logic        w_full_q;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_go;    // Both halves present
    logic        wr_hit;   // Mapped address

    assign s_axi_awready_o = !aw_full_q;
    assign s_axi_wready_o  = !w_full_q;
    assign wr_go  = aw_full_q && w_full_q && !s_axi_bvalid_o;
    assign wr_hit = (aw_addr_q == `SBDT_OFF_CTRL) || (aw_addr_q == `SBDT_OFF_STAT) ||
                    (aw_addr_q == `SBDT_OFF_VR_IDX) || (aw_addr_q == `SBDT_OFF_VR_DATA) ||
                    (aw_addr_q == `SBDT_OFF_PART);

    // Capture address and data channels
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_i && !aw_full_q)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr_i[31:2], 2'b00};
            end
            else if (wr_go)
                aw_full_q <= 1'b0;
            if (s_axi_wvalid_i && !w_full_q)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
            else if (wr_go)
                w_full_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `SBDT_RESP_OK;
        end
        else if (wr_go)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `SBDT_RESP_OK : `SBDT_RESP_ERR;
        end
        else if (s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
    end

    // Low byte strobe gates every field
    logic wr_ctrl;
    logic wr_low;
    assign wr_low   = wr_go && w_strb_q[0];
    assign wr_ctrl  = wr_low && (aw_addr_q == `SBDT_OFF_CTRL);
    assign lock_clr = wr_ctrl && lock_q && !w_data_q[`SBDT_CTRL_LOCK];
    assign ld_exit  = wr_ctrl && w_data_q[`SBDT_CTRL_LDEXIT];
    // Key only from the generator, and only while unlocked
    assign key_ld   = wr_ctrl && w_data_q[`SBDT_CTRL_KEYLD] && !lock_q;

    // Control fields
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pes_q       <= 1'b0;
            loader_entry_n_mask_q <= 4'h0;
            vr_idx_q    <= 6'h00;
        end
        else
        begin
            if (wr_ctrl)
                pes_q <= w_data_q[`SBDT_CTRL_PES];
            if (wr_low && (aw_addr_q == `SBDT_OFF_PART))
                loader_entry_n_mask_q <= w_data_q[3:0];
            if (wr_low && (aw_addr_q == `SBDT_OFF_VR_IDX))
                vr_idx_q <= w_data_q[5:0];
        end
    end

    // Lock: set only in loader mode; tamper clears it as well
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lock_q <= 1'b0;
        else if (tamper_s || lock_clr)
            lock_q <= 1'b0;
        else if (wr_ctrl && w_data_q[`SBDT_CTRL_LOCK] && (mode_q == SBDT_LOAD))
            lock_q <= 1'b1;
    end

    // Sticky tamper flag, write one to clear; a new event wins
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tamper_st_q <= 1'b0;
        else if (tamper_s)
            tamper_st_q <= 1'b1;
        else if (wr_low && (aw_addr_q == `SBDT_OFF_STAT) && w_data_q[`SBDT_ST_TAMPER])
            tamper_st_q <= 1'b0;
    end

    // Key store hookup; vector RAM writable only while unlocked
    assign kif.erase    = tamper_s || lock_clr;
    assign kif.key_load = key_ld;
    assign kif.trng     = trng_i;
    assign kif.vr_we    = wr_low && (aw_addr_q == `SBDT_OFF_VR_DATA) && !lock_q;
    assign kif.vr_idx   = vr_idx_q;
    assign kif.vr_wdata = w_data_q[7:0];
    // Key goes to the encryptors, never onto the register bus
    assign enc_key_o    = kif.key;

    sbdt_keystore u_keystore (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .kif     (kif)
    );

    // AXI read side
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case ({2'b00, s_axi_araddr_i[31:2]})
            `SBDT_OFF_CTRL >> 2:    rd_word = {30'h0, lock_q, pes_q};
            `SBDT_OFF_STAT >> 2:    rd_word = {25'h0, lock_q, kif.key_valid, tamper_st_q,
                                               size32k_s, vcc_low_s, backup_s,
                                               mode_q == SBDT_LOAD};
            `SBDT_OFF_VR_IDX >> 2:  rd_word = {26'h0, vr_idx_q};
            // Locked vector RAM reads back zero
            `SBDT_OFF_VR_DATA >> 2: rd_word = {24'h0, lock_q ? 8'h00 : kif.vr_rdata};
            `SBDT_OFF_PART >> 2:    rd_word = {28'h0, loader_entry_n_mask_q};
            default:                rd_hit  = 1'b0;
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;

    // Read data registered one cycle after the address
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= `SBDT_RESP_OK;
        end
        else if (s_axi_arvalid_i && !s_axi_rvalid_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_hit ? `SBDT_RESP_OK : `SBDT_RESP_ERR;
        end
        else if (s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end

    // ---------------- Loader mode
    // Strap sampled on the edge the synchroniser output settles, so it still reads the resting level
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_q        <= SBDT_BOOT;
            boot_cnt_q    <= 2'h0;
            loader_prev_q <= 1'b1;
        end
        else
        begin
            loader_prev_q <= loader_n_s;
            case (mode_q)
                SBDT_BOOT:
                begin
                    boot_cnt_q <= boot_cnt_q + 2'h1;
                    if (boot_cnt_q == `SBDT_BOOT_CYC)
                        mode_q <= loader_n_s ? SBDT_NORM : SBDT_LOAD;
                end
                SBDT_NORM:
                begin
                    if (loader_prev_q && !loader_n_s)
                        mode_q <= SBDT_LOAD;
                end
                SBDT_LOAD:
                begin
                    if (ld_exit)
                        mode_q <= SBDT_NORM;
                end
                default: mode_q <= SBDT_BOOT;
            endcase
        end
    end

    assign loader_mode_o = (mode_q == SBDT_LOAD);

    // ---------------- Byte-wide decode
    logic [1:0] blk;      // 32k block number
    logic       p_hit;    // Peripheral space access
    logic [3:0] cs_raw_n; // Selects before backup gating
    logic [3:0] ps_raw_n; // Peripheral selects before gating
    logic       wr_ok;    // Write permitted

    assign blk   = mem_addr_i[16:15];
    assign p_hit = mem_req_i && mem_data_space_i && pes_q;

    always_comb
    begin
        cs_raw_n = 4'hf;
        ps_raw_n = 4'hf;
        if (p_hit)
            ps_raw_n[mem_addr_i[15:14]] = 1'b0;
        else if (mem_req_i && size32k_s)
            cs_raw_n[blk] = 1'b0;
        else if (mem_req_i)
            cs_raw_n = {1'b1, mem_addr_i[15], mem_addr_i[16], 1'b0};
    end

    // Program blocks are never written outside the loader
    assign wr_ok = p_hit || (mem_data_space_i && !loader_entry_n_mask_q[blk]) || loader_mode_o;

    // Registered pin outputs; battery gating on backed ones
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {chip_sel_block3_n_o, chip_sel_block2_n_o,
             chip_sel_block1_n_o, chip_sel_block0_n_o} <= 4'hf;
            chip_sel_block0_unbacked_n_o <= 1'b1;
            {periph_sel3_n_o, periph_sel2_n_o,
             periph_sel1_n_o, periph_sel0_n_o} <= 4'hf;
            write_strobe_n_o <= 1'b1;
        end
        else
        begin
            {chip_sel_block3_n_o, chip_sel_block2_n_o,
             chip_sel_block1_n_o, chip_sel_block0_n_o} <= cs_raw_n | {4{backup_s}};
            chip_sel_block0_unbacked_n_o <= cs_raw_n[0];
            periph_sel0_n_o <= ps_raw_n[0] | backup_s;
            periph_sel1_n_o <= ps_raw_n[1] | backup_s;
            periph_sel2_n_o <= ps_raw_n[2];
            periph_sel3_n_o <= ps_raw_n[3];
            write_strobe_n_o <= !(mem_req_i && mem_write_i && wr_ok && !backup_s);
        end
    end

    // ---------------- Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    backup_cs_hold_a: assert property ($past(backup_s) |-> chip_sel_block0_n_o &&
        chip_sel_block1_n_o && chip_sel_block2_n_o && chip_sel_block3_n_o && periph_sel0_n_o && periph_sel1_n_o)
        else $error("backed select active in backup");
    psel0_range_a: assert property ((p_hit && mem_addr_i[15:14] == 2'h0) |=>
        !periph_sel0_n_o || $past(backup_s))
        else $error("peripheral zero not selected");
    psel2_range_a: assert property ((p_hit && mem_addr_i[15:14] == 2'h2) |=> !periph_sel2_n_o)
        else $error("peripheral two not selected");
    no_pes_a: assert property (!pes_q |=> periph_sel3_n_o && periph_sel2_n_o)
        else $error("peripheral select with space off");
    cs3_size_a: assert property ((mem_req_i && !p_hit && !size32k_s) |=> chip_sel_block3_n_o)
        else $error("fourth select used in 128k mode");
    a16_map_a: assert property ((mem_req_i && !p_hit && !size32k_s && !backup_s) |=>
        chip_sel_block1_n_o == $past(mem_addr_i[16]) && chip_sel_block2_n_o == $past(mem_addr_i[15]))
        else $error("A16 or A15 mapping wrong");
    loader_entry_n_wp_a: assert property ((!mem_data_space_i && !loader_mode_o) |=> write_strobe_n_o)
        else $error("write strobe on program block");
    unbacked_a: assert property (!backup_s ##1 !backup_s |->
        chip_sel_block0_unbacked_n_o == chip_sel_block0_n_o)
        else $error("unbacked select differs");
    pin_reset_a: assert property (!pin_rst_n_s |-> core_reset_o)
        else $error("reset pin ignored");
    loader_edge_a: assert property ((mode_q == SBDT_NORM && loader_prev_q && !loader_n_s)
        |=> loader_mode_o)
        else $error("loader edge missed");
    tamper_lock_a: assert property (tamper_s |=> !lock_q && !switched_supply_out_o)
        else $error("tamper did not unlock");
endmodule // sbdt_top

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, ext_pull = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, mem_req_i = 0, mem_data_space_i = 0, mem_write_i = 0;
    logic loader_entry_n_i = 1, vcc_below_min_i = 0, vcc_below_batt_i = 0, mem_size_sel_i = 1;
    logic tamper_destroy_in_i = 0, power_fail_reset_io_n_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic [31:0] s_axi_awaddr_i = 0, s_axi_wdata_i = 0, s_axi_araddr_i = 0, s_axi_rdata_o, rd_q;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic [16:0] mem_addr_i = 0;
    logic [63:0] trng_i = 64'h0123_4567_89ab_cdef, enc_key_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rd_r;
    logic s_axi_arready_o, s_axi_rvalid_o, core_reset_o, loader_mode_o, power_fail_reset_io_n_o;
    logic power_fail_reset_io_n_oe_o, backup_active_n_o, switched_supply_out_o, chip_sel_block0_n_o;
    logic chip_sel_block1_n_o, chip_sel_block2_n_o, chip_sel_block3_n_o, chip_sel_block0_unbacked_n_o;
    logic periph_sel0_n_o, periph_sel1_n_o, periph_sel2_n_o, periph_sel3_n_o, write_strobe_n_o;
    logic [9:0] pins; // Selects and strobe, all active low
    int error_cnt = 0, num_checks = 0;
    assign pins = {chip_sel_block3_n_o, chip_sel_block2_n_o, chip_sel_block1_n_o, chip_sel_block0_n_o,
        chip_sel_block0_unbacked_n_o, periph_sel3_n_o, periph_sel2_n_o, periph_sel1_n_o, periph_sel0_n_o,
        write_strobe_n_o};
    sbdt_top i_dut (.*);
    sbdt_pin_model i_pin (.oe_i(power_fail_reset_io_n_oe_o), .pull_i(ext_pull), .pin_o(power_fail_reset_io_n_i));
    initial
        forever #25 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One register access; each channel released at its own handshake edge
    task automatic axi(input logic wr, input logic [31:0] a, d);
        logic ta, tw, tr, tb;
        int n;
        n = 0;
        @(posedge clk_i);
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} <= {a, d, a};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{wr}};
        {s_axi_arvalid_i, s_axi_rready_i} <= {2{!wr}};
        do
        begin
            @(negedge clk_i);
            {ta, tw, tr} = {s_axi_awready_o, s_axi_wready_o, s_axi_arready_o};
            tb = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
            rd_q = s_axi_rdata_o;
            rd_r = wr ? s_axi_bresp_o : s_axi_rresp_o;
            @(posedge clk_i);
            if (ta)
                s_axi_awvalid_i <= 0;
            if (tw)
                s_axi_wvalid_i <= 0;
            if (tr)
                s_axi_arvalid_i <= 0;
            if (tb)
                {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
            if (++n > 200)
            begin
                error_cnt++;
                report_and_stop();
            end
        end while (tb !== 1'b1);
    endtask
    // One bus cycle; decode shows on the sample edge, checked at the next falling edge
    task automatic acc(input logic [16:0] a, input logic ds, w, input logic [9:0] exp);
        @(posedge clk_i);
        {mem_req_i, mem_addr_i, mem_data_space_i, mem_write_i} <= {1'b1, a, ds, w};
        @(posedge clk_i);
        mem_req_i <= 0;
        @(negedge clk_i);
        check("decode", pins, exp);
        @(posedge clk_i);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_decode();
        check("idle", pins, 10'h3ff);
        axi(1, 32'h0, 32'h1);
        for (int i = 0; i < 4; i++)
            acc({1'b0, i[1:0], 14'h0}, 1, 0, 10'h3ff & ~(10'h002 << i));
        axi(1, 32'h0, 32'h0);
        for (int i = 0; i < 4; i++)
            acc({i[1:0], 15'h0}, 1, 0, 10'h3ff & ~(10'h040 << i) & ~(i == 0 ? 10'h020 : 10'h0));
        acc(17'h0, 0, 1, 10'h39f);
        acc(17'h0, 1, 1, 10'h39e);
        axi(1, 32'h10, 32'h1);
        acc(17'h0, 1, 1, 10'h39f);
        mem_size_sel_i <= 0;
        settle();
        acc(17'h18000, 1, 0, 10'h39f);
        acc(17'h08000, 1, 0, 10'h31f);
        mem_size_sel_i <= 1;
        settle();
    endtask
    task automatic t_backup();
        vcc_below_batt_i <= 1;
        settle();
        check("backup_n", backup_active_n_o, 0);
        acc(17'h0, 1, 0, 10'h3df);
        axi(1, 32'h0, 32'h1);
        acc(17'h0, 1, 0, 10'h3ff);
        acc(17'h0c000, 1, 0, 10'h3ef);
        axi(1, 32'h0, 32'h0);
        vcc_below_batt_i <= 0;
        settle();
    endtask
    task automatic t_power();
        vcc_below_min_i <= 1;
        settle();
        check("pf_pin", {power_fail_reset_io_n_oe_o, power_fail_reset_io_n_i, core_reset_o}, 3'h5);
        vcc_below_min_i <= 0;
        ext_pull <= 1;
        settle();
        check("ext_reset", core_reset_o, 1);
        ext_pull <= 0;
        settle();
        check("core_run", core_reset_o, 0);
    endtask
    task automatic t_strap();
        rst_n_i <= 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (8) @(posedge clk_i);
        check("strap", loader_mode_o, 1);
    endtask
    task automatic t_secure();
        axi(1, 32'h0, 32'h4);
        axi(0, 32'h4, 32'h0);
        check("key_valid", rd_q[5], 1);
        check("key_lo", enc_key_o[31:0], 32'h89ab_cdef);
        axi(1, 32'h8, 32'h5);
        axi(1, 32'hc, 32'ha5);
        axi(0, 32'hc, 32'h0);
        check("vram", rd_q, 32'ha5);
        tamper_destroy_in_i <= 1;
        settle();
        check("supply", switched_supply_out_o, 0);
        tamper_destroy_in_i <= 0;
        axi(0, 32'h4, 32'h0);
        check("tamper_st", rd_q[5:4], 2'h1);
        check("key_wipe", enc_key_o[31:0] | enc_key_o[63:32], 32'h0);
        axi(0, 32'hc, 32'h0);
        check("vram_wipe", rd_q, 32'h0);
        axi(0, 32'h40, 32'h0);
        check("unmapped", rd_r, 2'h2);
        loader_entry_n_i <= 0;
        settle();
        check("loader", loader_mode_o, 1);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (8) @(posedge clk_i);
        check("boot", {loader_mode_o, switched_supply_out_o, backup_active_n_o}, 3'h3);
        t_decode();
        t_backup();
        t_power();
        t_secure();
        t_strap();
        report_and_stop();
    end
endmodule // testbench
